// ===== rtl/lrs_pkg.sv
// constants and types for the refresh scheduling block
`default_nettype none
package lrs_pkg;
	localparam int NUM_BANKS = 8;
	localparam int BANK_W = 3;
	localparam logic [BANK_W-1:0] BANK_ZERO = 3'h0;
	localparam logic [BANK_W-1:0] BANK_LAST = 3'h7;
	localparam logic [BANK_W-1:0] BANK_STEP = 3'h1;
	localparam int CA_W = 10;
	localparam int CA_REF_BIT = 3;
	localparam logic [2:0] CA_REF_CODE = 3'h4;
	localparam int CNT_W = 16;
	localparam logic [CNT_W-1:0] CNT_ZERO = 16'h0000;
	localparam logic [CNT_W-1:0] CNT_ONE = 16'h0001;
	// nanosecond figures, cycle counts derived at 5 ns
	localparam int CLK_PS = 5000;
	localparam int TRFCAB_NS = 130;
	localparam int TRFCPB_NS = 60;
	localparam int TRFCAB_CYC = (TRFCAB_NS * 1000 + CLK_PS - 1) / CLK_PS;
	localparam int TRFCPB_CYC = (TRFCPB_NS * 1000 + CLK_PS - 1) / CLK_PS;
	typedef enum logic [1:0] {LRS_REF_NONE, LRS_REF_PB, LRS_REF_AB} lrs_ref_t;
endpackage
`default_nettype wire

// ===== rtl/lrs_ref_if.sv
// command decode results shared between the decoder and the scheduler
`default_nettype none
interface lrs_ref_if;
	logic ref_pb;
	logic ref_ab;
	logic illegal;
	modport dec (output ref_pb, output ref_ab, output illegal);
	modport sched (input ref_pb, input ref_ab, input illegal);
endinterface
`default_nettype wire

// ===== rtl/lrs_cmd_dec.sv
// refresh command decoder on the rising-edge half of the ca bus
`default_nettype none
module lrs_cmd_dec (
	input wire logic cs_n_i,
	input wire logic [lrs_pkg::CA_W-1:0] ca_i,
	input wire logic eight_banks_i,
	lrs_ref_if.dec ref_o
);
	wire is_ref;
	wire all_bank;
	assign is_ref = !cs_n_i && (ca_i[2:0] == lrs_pkg::CA_REF_CODE);
	assign all_bank = ca_i[lrs_pkg::CA_REF_BIT];
	assign ref_o.ref_ab = is_ref && all_bank;
	// fewer banks: per-bank pattern is flagged, never acted on
	assign ref_o.ref_pb = is_ref && !all_bank && eight_banks_i;
	assign ref_o.illegal = is_ref && !all_bank && !eight_banks_i;
endmodule
`default_nettype wire

// ===== rtl/lrs_refresh.sv
// per-bank refresh counter and refresh busy tracking inside the memory
`default_nettype none
module lrs_refresh (
	input wire logic sys_clk_i,
	input wire logic nrst_i,
	input wire logic ce_i,
	input wire logic cs_n_i,
	input wire logic [lrs_pkg::CA_W-1:0] ca_i,
	input wire logic eight_banks_i,
	input wire logic reset_cmd_i,
	input wire logic sr_exit_i,
	output logic [lrs_pkg::BANK_W-1:0] next_bank_o,
	output logic [lrs_pkg::NUM_BANKS-1:0] bank_busy_o,
	output logic ref_pb_o,
	output logic ref_ab_o,
	output logic ref_illegal_o,
	output logic [lrs_pkg::CNT_W-1:0] ab_count_o
);
	lrs_ref_if dec_if ();

	lrs_cmd_dec u_dec (
		.cs_n_i(cs_n_i),
		.ca_i(ca_i),
		.eight_banks_i(eight_banks_i),
		.ref_o(dec_if.dec)
	);

	logic [lrs_pkg::BANK_W-1:0] bank_ff;
	logic [lrs_pkg::CNT_W-1:0] ab_timer_ff;
	logic [lrs_pkg::CNT_W-1:0] pb_timer_ff;
	logic [lrs_pkg::BANK_W-1:0] pb_bank_ff;
	logic ref_pb_ff;
	logic ref_ab_ff;
	logic illegal_ff;
	logic [lrs_pkg::CNT_W-1:0] ab_count_ff;

	function automatic logic [lrs_pkg::CNT_W-1:0] dec_sat(input logic [lrs_pkg::CNT_W-1:0] v);
		dec_sat = (v == lrs_pkg::CNT_ZERO) ? lrs_pkg::CNT_ZERO : v - lrs_pkg::CNT_ONE;
	endfunction

	wire counter_clear;
	wire [lrs_pkg::BANK_W-1:0] bank_inc;
	wire [lrs_pkg::BANK_W-1:0] nxt_bank;
	wire [lrs_pkg::CNT_W-1:0] nxt_ab_timer;
	wire [lrs_pkg::CNT_W-1:0] nxt_pb_timer;
	wire [lrs_pkg::CNT_W-1:0] nxt_ab_count;
	wire [lrs_pkg::NUM_BANKS-1:0] pb_busy_vec;

	// clear sources take priority over a step in the same cycle
	assign counter_clear = reset_cmd_i || sr_exit_i || dec_if.ref_ab;
	assign bank_inc = (bank_ff == lrs_pkg::BANK_LAST) ? lrs_pkg::BANK_ZERO : bank_ff + lrs_pkg::BANK_STEP;
	assign nxt_bank = counter_clear ? lrs_pkg::BANK_ZERO : (dec_if.ref_pb ? bank_inc : bank_ff);
	assign nxt_ab_timer = dec_if.ref_ab ? lrs_pkg::CNT_W'(lrs_pkg::TRFCAB_CYC) : dec_sat(ab_timer_ff);
	assign nxt_pb_timer = dec_if.ref_pb ? lrs_pkg::CNT_W'(lrs_pkg::TRFCPB_CYC) : dec_sat(pb_timer_ff);
	assign nxt_ab_count = dec_if.ref_ab ? ab_count_ff + lrs_pkg::CNT_ONE : ab_count_ff;
	// only the refreshed bank is marked, others stay usable
	assign pb_busy_vec = (pb_timer_ff != lrs_pkg::CNT_ZERO) ?
		(lrs_pkg::NUM_BANKS'(1) << pb_bank_ff) : '0;

	always_ff @(posedge sys_clk_i) begin
		if (!nrst_i) begin
			bank_ff <= lrs_pkg::BANK_ZERO;
			ab_timer_ff <= lrs_pkg::CNT_ZERO;
			pb_timer_ff <= lrs_pkg::CNT_ZERO;
			pb_bank_ff <= lrs_pkg::BANK_ZERO;
			ref_pb_ff <= 1'b0;
			ref_ab_ff <= 1'b0;
			illegal_ff <= 1'b0;
			ab_count_ff <= lrs_pkg::CNT_ZERO;
		end else if (ce_i) begin
			bank_ff <= nxt_bank;
			ab_timer_ff <= nxt_ab_timer;
			pb_timer_ff <= nxt_pb_timer;
			if (dec_if.ref_pb) begin
				pb_bank_ff <= bank_ff;
			end
			ref_pb_ff <= dec_if.ref_pb;
			ref_ab_ff <= dec_if.ref_ab;
			illegal_ff <= dec_if.illegal;
			ab_count_ff <= nxt_ab_count;
		end
	end

	// all banks busy after all-bank refresh, counters freeze with ce low
	assign bank_busy_o = (ab_timer_ff != lrs_pkg::CNT_ZERO) ? '1 : pb_busy_vec;
	assign next_bank_o = bank_ff;
	assign ref_pb_o = ref_pb_ff;
	assign ref_ab_o = ref_ab_ff;
	assign ref_illegal_o = illegal_ff;
	assign ab_count_o = ab_count_ff;

	default clocking cb @(posedge sys_clk_i); endclocking
	default disable iff (!nrst_i);

	bank_wrap_a: assert property (ce_i && dec_if.ref_pb && !counter_clear && bank_ff == lrs_pkg::BANK_LAST
		|=> bank_ff == lrs_pkg::BANK_ZERO) else $error("bank counter did not wrap");
	bank_step_a: assert property (ce_i && dec_if.ref_pb && !counter_clear && bank_ff != lrs_pkg::BANK_LAST
		|=> bank_ff == $past(bank_ff) + lrs_pkg::BANK_STEP) else $error("bank counter did not step");
	sync_clear_a: assert property (ce_i && (reset_cmd_i || sr_exit_i)
		|=> bank_ff == lrs_pkg::BANK_ZERO) else $error("counter not cleared");
	ab_clear_a: assert property (ce_i && dec_if.ref_ab |=> bank_ff == lrs_pkg::BANK_ZERO && ref_ab_o)
		else $error("all-bank refresh did not clear counter");
	ref_decode_a: assert property (ce_i && !cs_n_i && ca_i[2:0] == lrs_pkg::CA_REF_CODE
		|=> ref_ab_o || ref_pb_o || ref_illegal_o) else $error("refresh not decoded");
	pb_kind_a: assert property (ce_i && dec_if.ref_pb |-> !ca_i[lrs_pkg::CA_REF_BIT])
		else $error("per-bank with ca3 high");
	four_bank_a: assert property (!eight_banks_i |-> !dec_if.ref_pb)
		else $error("per-bank accepted on four banks");
	pb_busy_a: assert property (ce_i && dec_if.ref_pb && !dec_if.ref_ab && ab_timer_ff == lrs_pkg::CNT_ZERO
		|=> bank_busy_o[pb_bank_ff] && $countones(bank_busy_o) == 1) else $error("per-bank busy wrong");
	ab_busy_a: assert property (ce_i && dec_if.ref_ab |=> bank_busy_o == '1 [*2])
		else $error("all-bank busy missing");
	pb_done_a: assert property (pb_timer_ff == lrs_pkg::CNT_ONE && ce_i && !dec_if.ref_pb
		&& !dec_if.ref_ab && ab_timer_ff == lrs_pkg::CNT_ZERO |=> bank_busy_o == '0)
		else $error("bank not idle after tRFCpb");
	// other commands, auto-precharge bursts included, never touch refresh state
	other_cmd_a: assert property (ce_i && (cs_n_i || ca_i[2:0] != lrs_pkg::CA_REF_CODE) && !reset_cmd_i && !sr_exit_i
		|=> $stable(bank_ff) && !ref_pb_o && !ref_ab_o) else $error("non-refresh command disturbed refresh");

	pb_seen_c: cover property (ce_i && dec_if.ref_pb);
	ab_seen_c: cover property (ce_i && dec_if.ref_ab);
	wrap_seen_c: cover property (ce_i && dec_if.ref_pb && bank_ff == lrs_pkg::BANK_LAST);
	exit_seen_c: cover property (ce_i && sr_exit_i && bank_ff != lrs_pkg::BANK_ZERO);
endmodule
`default_nettype wire

// ===== verif/lrs_ctl_model.sv
// behavioural memory controller issuing refresh commands
`default_nettype none
module lrs_ctl_model (
	input wire logic sys_clk_i,
	output logic cs_n_o,
	output logic [lrs_pkg::CA_W-1:0] ca_o
);
	timeunit 1ns;
	timeprecision 100ps;
	initial begin
		cs_n_o = 1'b1;
		ca_o = 10'h3F0;
	end
	// never activates, so every bank stays idle
	// no precharge issued, so no precharge period to honour
	// run is far shorter than a refresh window and never self-refreshes
	task automatic send(input logic ab);
		cs_n_o = 1'b0;
		ca_o = {6'h2A, ab, 3'h4};
		@(posedge sys_clk_i);
		#1;
		cs_n_o = 1'b1;
		ca_o = ~ca_o; // released bus must not echo the command
	endtask
	// extra gap after all-bank so a burst window never holds more than eight
	task automatic pace(input logic ab);
		if (ab) begin
			repeat (3 * lrs_pkg::TRFCAB_CYC) @(posedge sys_clk_i);
			#1;
		end
	endtask
	// spacing before the next refresh, in rounded-up cycles
	task automatic settle(input logic ab);
		repeat (ab ? lrs_pkg::TRFCAB_CYC : lrs_pkg::TRFCPB_CYC) @(posedge sys_clk_i);
		#1;
	endtask
endmodule
`default_nettype wire

// ===== verif/testbench.sv
// random refresh command stream against the refresh block
`default_nettype none
module testbench;
	timeunit 1ns;
	timeprecision 100ps;
	logic clk = 1'b0, nrst = 1'b0, ce = 1'b1, eight = 1'b1, rst_cmd = 1'b0, sr_exit = 1'b0;
	logic cs_n, pb, ab, ill;
	logic [lrs_pkg::CA_W-1:0] ca;
	logic [lrs_pkg::BANK_W-1:0] nb, exp_bank = 3'h0;
	logic [lrs_pkg::NUM_BANKS-1:0] busy;
	logic [lrs_pkg::CNT_W-1:0] abc, exp_abc = 16'h0000;
	logic [31:0] seed = 32'h8974830B;
	int error_cnt = 0, checks = 0;
	always #2.5 clk = ~clk;
	lrs_ctl_model ctl (.sys_clk_i(clk), .cs_n_o(cs_n), .ca_o(ca));
	lrs_refresh uut (.sys_clk_i(clk), .nrst_i(nrst), .ce_i(ce), .cs_n_i(cs_n), .ca_i(ca), .eight_banks_i(eight),
		.reset_cmd_i(rst_cmd), .sr_exit_i(sr_exit), .next_bank_o(nb), .bank_busy_o(busy), .ref_pb_o(pb),
		.ref_ab_o(ab), .ref_illegal_o(ill), .ab_count_o(abc));
	function automatic logic [31:0] xorshift(input logic [31:0] s);
		s = s ^ (s << 13);
		s = s ^ (s >> 17);
		return s ^ (s << 5);
	endfunction
	task automatic check(input logic [31:0] seen, input logic [31:0] want, input string what);
		checks++;
		if (seen !== want) begin
			error_cnt++;
			$display("unexpected at %0t: %s seen %h expected %h", $time, what, seen, want);
		end
	endtask
	// clr pulses a reset command or self-refresh exit alongside the refresh
	task automatic refresh(input logic all, input logic clr, input logic en);
		logic [2:0] want;
		logic [7:0] hit;
		want = !en ? 3'h0 : all ? 3'h2 : eight ? 3'h4 : 3'h1;
		hit = (!en || (!all && !eight)) ? 8'h00 : all ? 8'hFF : 8'h01 << exp_bank;
		ce = en;
		rst_cmd = clr & en & seed[10];
		sr_exit = clr & en & ~seed[10];
		ctl.send(all);
		ce = 1'b1;
		rst_cmd = 1'b0;
		sr_exit = 1'b0;
		if (en && (all || clr))
			exp_bank = 3'h0;
		else if (en && eight)
			exp_bank = exp_bank + 3'h1;
		if (en && all)
			exp_abc = exp_abc + 16'h0001;
		check({pb, ab, ill}, want, "pulse");
		check(nb, exp_bank, "bank");
		check(abc, exp_abc, "count");
		check(busy, hit, "busy");
		ctl.settle(all);
		check(busy, 8'h00, "idle");
		check({pb, ab, ill}, 3'h0, "quiet");
		ctl.pace(all);
	endtask
	task automatic tally_and_finish();
		$display("checks %0d errors %0d", checks, error_cnt);
		if (error_cnt == 0 && checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	initial begin
		repeat (12) @(posedge clk);
		#1;
		nrst = 1'b1;
		// full lap plus wrap, then all-bank clear mid-lap
		repeat (11) refresh(1'b0, 1'b0, 1'b1);
		refresh(1'b1, 1'b0, 1'b1);
		for (int i = 0; i < 90; i++) begin
			seed = xorshift(seed);
			eight = seed[4:2] != 3'h0;
			refresh(seed[1:0] == 2'h0, seed[9:8] == 2'h0, seed[7:5] != 3'h0);
		end
		// second reset mid-run clears counter and tally
		nrst = 1'b0;
		@(posedge clk);
		#1;
		nrst = 1'b1;
		exp_bank = 3'h0;
		exp_abc = 16'h0000;
		check(abc, exp_abc, "reset");
		check(nb, exp_bank, "reset bank");
		check(busy, 8'h00, "reset busy");
		refresh(1'b0, 1'b0, 1'b1);
		tally_and_finish();
	end
	// run needs about 3500 cycles
	initial begin
		#100000;
		error_cnt++;
		tally_and_finish();
	end
endmodule
`default_nettype wire
